//--- soc_handler.sv
// Purpose: Task-file command handler for off-line data collection and result readout.
// Assumes: APB master; synchronous active-high reset; inputs synchronous to clk_sys.
// Notes: Collection runs in the background and is halted by any new command.

// Overview of operation
// - B0h with features D4h starts collection.
// - Collection command has no data phase.
// - Packet devices and unimplemented option abort.
// - Abort on unsupported, disabled or bad keys.
// - Normal end: BSY low, DRDY high, clean.
// - Missing result sector sets IDNF bit four.
// - Invalid or unsupported B0h feature sets ABRT bit.
// - Error end: ERR follows error bits, DF.
// - Device select bit reads back selected device.
// - Accepted command starts collection, stores results.
// - Collection keeps BSY low, DRDY high.
// - Other commands halt collection within two seconds.
// - Collection resumes after an error-free interrupting command with no data phase ends.
// - Standby halts; power-up command resumes collection.
// - Disable halts; next enable resumes collection.
// - New collection command aborts and restarts.
// - B0h with D0h is read-data, PIO in.
// - Capability bit two selects abort over suspend.
// - Status byte records outcome 02/04/05/06.
module soc_handler #(
  parameter int SERVICE_CYCLES = soc_pkg::SERVICE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  soc_pkg::soc_taskfile_t taskfile;
  soc_pkg::soc_coll_t collState;
  soc_pkg::soc_cmd_t cmdState;
  logic [7:0] config_;
  logic [7:0] cmdCode;
  logic [7:0] errorBits;
  logic [7:0] collectStatus;
  logic [soc_pkg::SERVICE_W-1:0] serviceCount;
  logic [2:0] tickCount;
  logic [soc_pkg::STORE_AW-1:0] writePtr;
  logic [soc_pkg::STORE_AW-1:0] readPtr;
  logic [7:0] sampleValue;
  logic [7:0] storeData;
  logic busy;
  logic drq;
  logic deviceFault;
  logic faultPending;
  logic smartEnabled;
  logic powerSave;
  logic tick;
  logic apbWrite;
  logic apbRead;
  logic cmdWrite;
  logic completing;
  logic storeStep;
  logic resumeOk;
  logic [7:0] next_errorBits;
  logic next_drq;
  logic next_smartEnabled;
  logic next_powerSave;
  logic startCollect;
  logic [7:0] readMux;
  logic mapped;

  // True when the feature code under a B0h command matches the given one.
  function automatic logic isSmart(input logic [7:0] code, input logic [7:0] feat,
                                   input logic [7:0] want);
    isSmart = (code == soc_pkg::CMD_SMART) && (feat == want);
  endfunction

  // True when both cylinder key registers hold the key values.
  function automatic logic keysOk(input soc_pkg::soc_taskfile_t tf);
    keysOk = (tf.cylLow == soc_pkg::KEY_LOW) && (tf.cylHigh == soc_pkg::KEY_HIGH);
  endfunction

  assign apbWrite = psel && penable && pready && pwrite;
  assign apbRead = psel && penable && pready && !pwrite;
  // Commands written while busy are ignored, as the task file is owned by the device then.
  assign cmdWrite = apbWrite && (paddr == soc_pkg::ADDR_COMMAND) && !busy;
  // The host must not wait longer than the service limit for completion.
  assign completing = (cmdState == soc_pkg::CMD_EXEC) &&
                      ((collState != soc_pkg::COLL_RUNNING) || (serviceCount == '0));
  assign storeStep = (collState == soc_pkg::COLL_RUNNING) && tick && !cmdWrite &&
                     !config_[soc_pkg::CFG_FAULT];
  assign sampleValue = {tickCount, writePtr, 1'b1};

  // Sample divider for the collection pace.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickCount <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tickCount == soc_pkg::SAMPLE_LAST);
      tickCount <= (tickCount == soc_pkg::SAMPLE_LAST) ? '0 : tickCount + 3'h1;
    end
  end

  // Outcome of the command under execution.
  always_comb begin
    next_errorBits = 8'h00;
    next_drq = 1'b0;
    next_smartEnabled = smartEnabled;
    next_powerSave = 1'b0;
    startCollect = 1'b0;
    // A fault found during collection fails the next command, so DF only shows on error.
    if (faultPending) begin
      next_errorBits[soc_pkg::ERR_ABRT] = 1'b1;
    end else if (cmdCode == soc_pkg::CMD_SMART) begin
      if (config_[soc_pkg::CFG_PACKET] || !keysOk(taskfile)) begin
        next_errorBits[soc_pkg::ERR_ABRT] = 1'b1;
      end else if (isSmart(cmdCode, taskfile.features, soc_pkg::FEAT_OFFLINE)) begin
        if (!config_[soc_pkg::CFG_IMPL] || !smartEnabled) begin
          next_errorBits[soc_pkg::ERR_ABRT] = 1'b1;
        end else if (config_[soc_pkg::CFG_IDNF]) begin
          next_errorBits[soc_pkg::ERR_IDNF] = 1'b1;
        end else begin
          startCollect = 1'b1;
        end
      end else if (isSmart(cmdCode, taskfile.features, soc_pkg::FEAT_READ)) begin
        if (!smartEnabled) begin
          next_errorBits[soc_pkg::ERR_ABRT] = 1'b1;
        end else if (config_[soc_pkg::CFG_IDNF]) begin
          next_errorBits[soc_pkg::ERR_IDNF] = 1'b1;
        end else begin
          next_drq = 1'b1;
        end
      end else if (isSmart(cmdCode, taskfile.features, soc_pkg::FEAT_ENABLE)) begin
        next_smartEnabled = 1'b1;
      end else if (isSmart(cmdCode, taskfile.features, soc_pkg::FEAT_DISABLE) &&
                   smartEnabled) begin
        next_smartEnabled = 1'b0;
      end else begin
        next_errorBits[soc_pkg::ERR_ABRT] = 1'b1;
      end
    end else if (cmdCode == soc_pkg::CMD_STANDBY) begin
      next_powerSave = 1'b1;
    end
  end

  // A suspended run resumes when a command completes leaving the device enabled, awake, error-free and not transferring.
  assign resumeOk = next_smartEnabled && !next_powerSave && !next_drq &&
                    (next_errorBits == 8'h00);

  // Command sequencing and the service limit counter.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmdState <= soc_pkg::CMD_IDLE;
      cmdCode <= 8'h00;
      serviceCount <= '0;
    end else begin
      case (cmdState)
        soc_pkg::CMD_IDLE: begin
          if (cmdWrite) begin
            cmdState <= soc_pkg::CMD_EXEC;
            cmdCode <= pwdata[7:0];
            serviceCount <= soc_pkg::SERVICE_W'(SERVICE_CYCLES);
          end
        end
        soc_pkg::CMD_EXEC: begin
          if (completing) begin
            cmdState <= soc_pkg::CMD_IDLE;
          end else if (serviceCount != '0) begin
            serviceCount <= serviceCount - 1'b1;
          end
        end
        default: cmdState <= soc_pkg::CMD_IDLE;
      endcase
    end
  end

  // Completion status seen by the host.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busy <= 1'b0;
      drq <= 1'b0;
      deviceFault <= 1'b0;
      errorBits <= 8'h00;
      smartEnabled <= 1'b0;
      powerSave <= 1'b0;
    end else if (cmdWrite) begin
      busy <= 1'b1;
      drq <= 1'b0;
    end else if (completing) begin
      busy <= 1'b0;
      drq <= next_drq;
      deviceFault <= faultPending;
      errorBits <= next_errorBits;
      smartEnabled <= next_smartEnabled;
      powerSave <= next_powerSave;
    end else if (apbRead && (paddr == soc_pkg::ADDR_DATA) && drq &&
                 (readPtr == soc_pkg::STORE_LAST)) begin
      drq <= 1'b0;
    end
  end

  // Background collection state and outcome byte.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      collState <= soc_pkg::COLL_IDLE;
      collectStatus <= soc_pkg::OLS_NEVER;
      writePtr <= '0;
      faultPending <= 1'b0;
    end else if (cmdWrite && (collState == soc_pkg::COLL_RUNNING)) begin
      if (isSmart(pwdata[7:0], taskfile.features, soc_pkg::FEAT_OFFLINE) ||
          config_[soc_pkg::CFG_HOST_ABORT]) begin
        collState <= soc_pkg::COLL_ABORTED;
        collectStatus <= soc_pkg::OLS_HOST_ABORT;
      end else begin
        collState <= soc_pkg::COLL_SUSPENDED;
        collectStatus <= soc_pkg::OLS_SUSPENDED;
      end
    end else if (completing) begin
      faultPending <= 1'b0;
      if (startCollect) begin
        collState <= soc_pkg::COLL_RUNNING;
        writePtr <= '0;
      end else if ((collState == soc_pkg::COLL_SUSPENDED) && resumeOk) begin
        collState <= soc_pkg::COLL_RUNNING;
      end
    end else if ((collState == soc_pkg::COLL_RUNNING) && config_[soc_pkg::CFG_FAULT]) begin
      collState <= soc_pkg::COLL_ABORTED;
      collectStatus <= soc_pkg::OLS_DEV_ABORT;
      faultPending <= 1'b1;
    end else if (storeStep) begin
      writePtr <= writePtr + 1'b1;
      if (writePtr == soc_pkg::STORE_LAST) begin
        collState <= soc_pkg::COLL_IDLE;
        collectStatus <= soc_pkg::OLS_DONE;
      end
    end
  end

  // Readout pointer for the data-in transfer.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      readPtr <= '0;
    end else if (completing && next_drq) begin
      readPtr <= '0;
    end else if (apbRead && (paddr == soc_pkg::ADDR_DATA) && drq) begin
      readPtr <= readPtr + 1'b1;
    end
  end

  soc_result_store store (
    .clk_sys(clk_sys),
    .writeEn(storeStep),
    .writeAddr(writePtr),
    .writeData(sampleValue),
    .readAddr(readPtr),
    .readData(storeData)
  );

  // Task file and configuration writes; the task file is locked while busy.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      taskfile <= {4{soc_pkg::TASKFILE_RESET}};
      config_ <= soc_pkg::CONFIG_RESET;
    end else if (apbWrite) begin
      case (paddr)
        soc_pkg::ADDR_FEATURES: begin
          if (!busy) begin
            taskfile.features <= pwdata[7:0];
          end
        end
        soc_pkg::ADDR_CYL_LOW: begin
          if (!busy) begin
            taskfile.cylLow <= pwdata[7:0];
          end
        end
        soc_pkg::ADDR_CYL_HIGH: begin
          if (!busy) begin
            taskfile.cylHigh <= pwdata[7:0];
          end
        end
        soc_pkg::ADDR_DEV_SELECT: begin
          if (!busy) begin
            taskfile.devSelect <= pwdata[7:0];
          end
        end
        soc_pkg::ADDR_CONFIG: config_ <= {3'b000, pwdata[4:0]};
        default: config_ <= config_;
      endcase
    end
  end

  // Read multiplexer and address decode.
  always_comb begin
    readMux = 8'h00;
    mapped = 1'b1;
    case (paddr)
      soc_pkg::ADDR_FEATURES: readMux = 8'h00;
      soc_pkg::ADDR_CYL_LOW: readMux = taskfile.cylLow;
      soc_pkg::ADDR_CYL_HIGH: readMux = taskfile.cylHigh;
      soc_pkg::ADDR_DEV_SELECT: readMux = taskfile.devSelect;
      soc_pkg::ADDR_COMMAND: readMux = 8'h00;
      soc_pkg::ADDR_STATUS: begin
        readMux[soc_pkg::STS_BSY] = busy;
        readMux[soc_pkg::STS_DRDY] = !busy;
        readMux[soc_pkg::STS_DF] = deviceFault;
        readMux[soc_pkg::STS_DRQ] = drq;
        readMux[soc_pkg::STS_ERR] = |errorBits;
      end
      soc_pkg::ADDR_ERROR: readMux = errorBits;
      soc_pkg::ADDR_CONFIG: readMux = config_;
      soc_pkg::ADDR_COLLECT: readMux = collectStatus;
      soc_pkg::ADDR_DATA: readMux = drq ? storeData : 8'h00;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: one wait state, then ready with registered data.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h000000, readMux};
        pslverr <= !mapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule

//--- soc_pkg.sv
// Purpose: Shared constants and types for the off-line collection command handler.
// Assumes: One 25 MHz clock, APB register access with 32-bit data.
// Notes: Offsets are byte addresses on the APB slave.
package soc_pkg;
  // Command and feature codes.
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] CMD_STANDBY = 8'hE0;
  localparam logic [7:0] FEAT_OFFLINE = 8'hD4;
  localparam logic [7:0] FEAT_READ = 8'hD0;
  localparam logic [7:0] FEAT_ENABLE = 8'hD8;
  localparam logic [7:0] FEAT_DISABLE = 8'hD9;
  localparam logic [7:0] KEY_LOW = 8'h4F;
  localparam logic [7:0] KEY_HIGH = 8'hC2;

  // Register byte offsets.
  localparam logic [7:0] ADDR_FEATURES = 8'h00;
  localparam logic [7:0] ADDR_CYL_LOW = 8'h04;
  localparam logic [7:0] ADDR_CYL_HIGH = 8'h08;
  localparam logic [7:0] ADDR_DEV_SELECT = 8'h0C;
  localparam logic [7:0] ADDR_COMMAND = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_ERROR = 8'h18;
  localparam logic [7:0] ADDR_CONFIG = 8'h1C;
  localparam logic [7:0] ADDR_COLLECT = 8'h20;
  localparam logic [7:0] ADDR_DATA = 8'h24;

  // Bit positions.
  localparam int STS_BSY = 7;
  localparam int STS_DRDY = 6;
  localparam int STS_DF = 5;
  localparam int STS_DRQ = 3;
  localparam int STS_ERR = 0;
  localparam int ERR_IDNF = 4;
  localparam int ERR_ABRT = 2;
  localparam int CFG_IMPL = 0;
  localparam int CFG_PACKET = 1;
  localparam int CFG_HOST_ABORT = 2;
  localparam int CFG_IDNF = 3;
  localparam int CFG_FAULT = 4;

  // Reset values.
  localparam logic [7:0] CONFIG_RESET = 8'h01;
  localparam logic [7:0] TASKFILE_RESET = 8'h00;

  // Collection status byte values.
  localparam logic [7:0] OLS_NEVER = 8'h00;
  localparam logic [7:0] OLS_DONE = 8'h02;
  localparam logic [7:0] OLS_SUSPENDED = 8'h04;
  localparam logic [7:0] OLS_HOST_ABORT = 8'h05;
  localparam logic [7:0] OLS_DEV_ABORT = 8'h06;

  // Timing.
  localparam int CLK_HZ = 25_000_000;
  localparam int SERVICE_LIMIT_S = 2;
  localparam int SERVICE_CYCLES = SERVICE_LIMIT_S * CLK_HZ;
  localparam int SERVICE_W = 26;
  localparam int SAMPLE_DIV = 8;
  localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_DIV - 1);

  // Result store geometry.
  localparam int STORE_DEPTH = 16;
  localparam int STORE_AW = 4;
  localparam logic [3:0] STORE_LAST = 4'(STORE_DEPTH - 1);

  typedef enum logic [1:0] {COLL_IDLE, COLL_RUNNING, COLL_SUSPENDED, COLL_ABORTED} soc_coll_t;
  typedef enum logic {CMD_IDLE, CMD_EXEC} soc_cmd_t;

  typedef struct packed {
    logic [7:0] features;
    logic [7:0] cylLow;
    logic [7:0] cylHigh;
    logic [7:0] devSelect;
  } soc_taskfile_t;
endpackage

//--- soc_result_store.sv
// Purpose: Small store for collected results, standing in for non-volatile memory.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data come out of a register one cycle after the address.
module soc_result_store (
  // Clock
  input wire logic clk_sys,
  // Write side
  input wire logic writeEn,
  input wire logic [soc_pkg::STORE_AW-1:0] writeAddr,
  input wire logic [7:0] writeData,
  // Read side
  input wire logic [soc_pkg::STORE_AW-1:0] readAddr,
  output logic [7:0] readData
);
  logic [7:0] mem [soc_pkg::STORE_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule

//--- soc_handler_props.sv
// Purpose: Port-level checks for the task-file command handler.
// Assumes: One clock, synchronous active-high reset, APB slave ports only.
// Notes: Helper registers shadow what the host wrote last, and the ERR bit of the last status read.
module soc_handler_props #(
  parameter int SERVICE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [7:0] lastFeat;
  logic readMode;
  logic devBit;
  logic errSeen;
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic rdDone = psel && penable && pready && !pwrite;
  wire logic mapped = paddr[1:0] == 2'h0 && paddr <= 8'h24;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lastFeat <= 8'h00;
      readMode <= 1'b0;
      devBit <= 1'b0;
      errSeen <= 1'b0;
    end else begin
      if (wrDone && paddr == soc_pkg::ADDR_FEATURES) lastFeat <= pwdata[7:0];
      if (wrDone && paddr == soc_pkg::ADDR_DEV_SELECT) devBit <= pwdata[4];
      if (wrDone && paddr == soc_pkg::ADDR_COMMAND) begin
        readMode <= pwdata[7:0] == soc_pkg::CMD_SMART && lastFeat == soc_pkg::FEAT_READ;
      end
      if (rdDone && paddr == soc_pkg::ADDR_STATUS) errSeen <= prdata[0];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [7:0] a);
    rdDone && paddr == a;
  endsequence
  property p_oneWait;
    s_setup ##1 (psel && penable) |-> !pready ##1 pready;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("pready not after one wait");
  property p_readyPulse;
    pready |=> !pready;
  endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("pready held too long");
  property p_slverr;
    pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0);
  endproperty
  a_slverr: assert property (p_slverr) else $error("bad error response");
  property p_upperZero;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper read bits set");
  property p_idleReady;
    s_read(soc_pkg::ADDR_STATUS) ##0 !prdata[7] |-> prdata[6];
  endproperty
  a_idleReady: assert property (p_idleReady) else $error("ready low while idle");
  property p_drqRead;
    s_read(soc_pkg::ADDR_STATUS) ##0 prdata[3] |-> readMode;
  endproperty
  a_drqRead: assert property (p_drqRead) else $error("data request outside read");
  property p_errFollows;
    s_read(soc_pkg::ADDR_ERROR) |-> errSeen == (prdata[7:0] != 8'h00);
  endproperty
  a_errFollows: assert property (p_errFollows) else $error("error bit mismatch");
  property p_devSel;
    s_read(soc_pkg::ADDR_DEV_SELECT) |-> prdata[4] == devBit;
  endproperty
  a_devSel: assert property (p_devSel) else $error("device bit wrong");
  property p_featWo;
    s_read(soc_pkg::ADDR_FEATURES) |-> prdata[7:0] == 8'h00;
  endproperty
  a_featWo: assert property (p_featWo) else $error("features readable");
endmodule
bind soc_handler soc_handler_props #(.SERVICE_CYCLES(SERVICE_CYCLES)) soc_handler_props_inst (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

//--- soc_host_model.sv
// Purpose: Host adapter model driving the task-file registers over APB.
// Assumes: Calls start right after a rising clock edge.
// Notes: Released write data shows the inverse of the last value.
module soc_host_model (
  // Clock
  input wire logic clk_sys,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  task automatic poll(input logic [1:0] want);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      xfer(1'b0, soc_pkg::ADDR_STATUS, 32'h0, q, e);
      n++;
    end while (q[7:6] !== want && n < 20);
    if (n >= 20) begin
      hangs++;
      $display("mismatch at %0t: device stayed busy", $time);
    end
  endtask
  task automatic issue(input logic [7:0] f, input logic [7:0] lo, input logic [7:0] code);
    logic [31:0] q;
    logic e;
    poll(2'b01);
    xfer(1'b1, soc_pkg::ADDR_FEATURES, {24'h0, f}, q, e);
    xfer(1'b1, soc_pkg::ADDR_CYL_LOW, {24'h0, lo}, q, e);
    xfer(1'b1, soc_pkg::ADDR_CYL_HIGH, {24'h0, soc_pkg::KEY_HIGH}, q, e);
    xfer(1'b1, soc_pkg::ADDR_COMMAND, {24'h0, code}, q, e);
    poll(2'b01);
  endtask
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the task-file command handler.
// Assumes: Short service limit; collection takes 128 clocks.
// Notes: Register traffic goes through the host model tasks.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [7:0] tc [4] = '{8'h01, 8'h01, 8'h05, 8'h01};
  logic [7:0] tf [4] = '{8'hD9, 8'hD8, 8'hD8, 8'hD4};
  logic [7:0] tk [4] = '{8'hB0, 8'hE0, 8'hB0, 8'hB0};
  logic [7:0] tm [4] = '{8'h04, 8'h04, 8'h05, 8'h05};
  logic [7:0] te [4] = '{8'h02, 8'h02, 8'h05, 8'h02};
  logic [7:0] ec [3] = '{8'h09, 8'h03, 8'h00};
  logic [7:0] ee [3] = '{8'h10, 8'h04, 8'h04};
  always #20 clk_sys = ~clk_sys;
  soc_handler #(.SERVICE_CYCLES(20)) soc_handler_inst (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  soc_host_model soc_host_model_inst (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));
  task automatic finishTest;
    failCount += soc_host_model_inst.hangs;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic expect8(input logic [7:0] a, input logic [7:0] exp);
    soc_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
    totalChecks++;
    if (q !== {24'h0, exp} || e !== 1'b0) begin
      failCount++;
      $display("mismatch at %0t: addr %h read %h want %h", $time, a, q, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    soc_host_model_inst.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic cmd(input logic [7:0] f, input logic [7:0] code, input logic [7:0] lo,
      input logic [7:0] st, input logic [7:0] er);
    soc_host_model_inst.issue(f, lo, code);
    expect8(soc_pkg::ADDR_STATUS, st);
    expect8(soc_pkg::ADDR_ERROR, er);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      failCount++;
      $display("mismatch at %0t: timeout", $time);
      finishTest();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    expect8(soc_pkg::ADDR_CONFIG, soc_pkg::CONFIG_RESET);
    expect8(soc_pkg::ADDR_STATUS, 8'h40);
    expect8(soc_pkg::ADDR_COLLECT, soc_pkg::OLS_NEVER);
    expect8(soc_pkg::ADDR_FEATURES, 8'h00);
    wr(soc_pkg::ADDR_DEV_SELECT, 8'h10);
    expect8(soc_pkg::ADDR_DEV_SELECT, 8'h10);
    soc_host_model_inst.xfer(1'b0, 8'h40, 32'h0, q, e);
    totalChecks++;
    if (e !== 1'b1 || q !== 32'h0) begin
      failCount++;
      $display("mismatch at %0t: unmapped read not refused", $time);
    end
    cmd(8'hD4, 8'hB0, 8'h4F, 8'h41, 8'h04);
    cmd(8'hD8, 8'hB0, 8'h4F, 8'h40, 8'h00);
    cmd(8'hD4, 8'hB0, 8'h00, 8'h41, 8'h04);
    cmd(8'h77, 8'hB0, 8'h4F, 8'h41, 8'h04);
    cmd(8'hD4, 8'hB0, 8'h4F, 8'h40, 8'h00);
    cmd(8'hD0, 8'hB0, 8'h4F, 8'h48, 8'h00);
    expect8(soc_pkg::ADDR_COLLECT, soc_pkg::OLS_SUSPENDED);
    for (int i = 0; i < 16; i++) begin
      soc_host_model_inst.xfer(1'b0, soc_pkg::ADDR_DATA, 32'h0, q, e);
    end
    expect8(soc_pkg::ADDR_STATUS, 8'h40);
    cmd(8'hD8, 8'hB0, 8'h4F, 8'h40, 8'h00);
    // A full collection run is 16 samples of 8 clocks each.
    repeat (150) @(posedge clk_sys);
    expect8(soc_pkg::ADDR_COLLECT, soc_pkg::OLS_DONE);
    for (int i = 0; i < 4; i++) begin
      wr(soc_pkg::ADDR_CONFIG, tc[i]);
      cmd(8'hD4, 8'hB0, 8'h4F, 8'h40, 8'h00);
      cmd(tf[i], tk[i], 8'h4F, 8'h40, 8'h00);
      if (i != 3) expect8(soc_pkg::ADDR_COLLECT, tm[i]);
      cmd(8'hD8, 8'hB0, 8'h4F, 8'h40, 8'h00);
      repeat (150) @(posedge clk_sys);
      expect8(soc_pkg::ADDR_COLLECT, te[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(soc_pkg::ADDR_CONFIG, ec[i]);
      cmd(8'hD4, 8'hB0, 8'h4F, 8'h41, ee[i]);
    end
    wr(soc_pkg::ADDR_CONFIG, 8'h01);
    cmd(8'hD4, 8'hB0, 8'h4F, 8'h40, 8'h00);
    wr(soc_pkg::ADDR_CONFIG, 8'h11);
    repeat (150) @(posedge clk_sys);
    expect8(soc_pkg::ADDR_COLLECT, soc_pkg::OLS_DEV_ABORT);
    cmd(8'hD8, 8'hB0, 8'h4F, 8'h61, 8'h04);
    cmd(8'hD8, 8'hB0, 8'h4F, 8'h40, 8'h00);
    finishTest();
  end
endmodule
